// File: astf_top.v
// Serial transmit framer with separate transmit and receive baud dividers set by one baud register, and oversampling receiver
`timescale 1ns/1ps
`default_nettype none
`include "astf_map.vh"
module astf_top (
	// APB
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Serial line
	output reg tx_out,
	output reg tx_oe,
	input wire rx_in,
	// Interrupts
	output wire irq,
	output wire irq_tx,
	output wire irq_rx
);
	localparam S_IDLE = 5'b00001;
	localparam S_START = 5'b00010;
	localparam S_DATA = 5'b00100;
	localparam S_STOP = 5'b01000;
	localparam S_BRK = 5'b10000;

	reg [15:0] baud_reg;
	reg [4:0] ctrl1_reg;
	reg [3:0] ctrl2_reg;
	reg [1:0] ctrl3_reg;
	reg [6:0] irq_en_reg;
	reg [6:0] status_reg;
	reg [8:0] hold_reg;
	reg hold_full_reg;
	reg [8:0] shift_reg;
	reg [4:0] state_reg;
	reg [3:0] bit_cnt_reg;
	reg [15:0] tx_div_reg;
	reg [3:0] tx_os_reg;
	reg idle_pend_reg;
	reg is_idle_reg;
	reg ten_d_reg;
	reg [1:0] rx_sync_reg;
	reg [15:0] rx_div_reg;
	reg [3:0] rx_os_reg;
	reg [2:0] rx_samp_reg;
	reg rx_busy_reg;
	reg [3:0] rx_bits_reg;
	reg [8:0] rx_shift_reg;
	reg [8:0] rx_data_reg;
	reg rx_noise_reg;

	wire wr = psel & penable & pwrite;
	wire rd = psel & penable & ~pwrite;
	wire hit = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);
	wire transmitter_enable = ctrl2_reg[`ASTF_C2_TEN];
	wire ren = ctrl2_reg[`ASTF_C2_REN];
	wire word9 = ctrl1_reg[`ASTF_C1_WORD9];
	wire two_stop = ctrl3_reg[0];
	wire wr_data = wr & (paddr == `ASTF_OFS_DATA);
	wire rd_data = rd & (paddr == `ASTF_OFS_DATA);
	wire wr_clr = wr & (paddr == `ASTF_OFS_IRQ_CLR);
	wire [15:0] div_max = (baud_reg < 16'h0001) ? 16'h0000 : (baud_reg - 16'h0001);
	// Sixteen sample ticks per bit; divisor is per sample tick
	wire tx_tick = transmitter_enable && (tx_div_reg == 16'h0000);
	wire tx_bit_end = tx_tick && (tx_os_reg == 4'hF);
	wire rx_tick = ren && (rx_div_reg == 16'h0000);
	wire [3:0] data_bits = word9 ? 4'd9 : 4'd8;
	wire [3:0] brk_bits = word9 ? 4'd11 : 4'd10;
	wire [3:0] stop_last = two_stop ? 4'd1 : 4'd0;
	wire frame_done = (state_reg == S_STOP) && tx_bit_end && (bit_cnt_reg == stop_last);
	wire [8:0] hold_word = word9 ? hold_reg : {1'b0, hold_reg[7:0]};
	wire rx_bit = (rx_samp_reg[0] & rx_samp_reg[1]) | (rx_samp_reg[1] & rx_samp_reg[2])
		| (rx_samp_reg[0] & rx_samp_reg[2]);
	wire rx_noisy = ~((rx_samp_reg == 3'b000) | (rx_samp_reg == 3'b111));

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign irq_tx = |(status_reg & irq_en_reg & `ASTF_IRQ_TX_MASK);
	assign irq_rx = |(status_reg & irq_en_reg & `ASTF_IRQ_RX_MASK);
	assign irq = irq_tx | irq_rx;

	always @* begin
		case (paddr)
			`ASTF_OFS_STATUS: prdata = {25'h0, status_reg};
			`ASTF_OFS_DATA: prdata = {23'h0, rx_data_reg};
			`ASTF_OFS_BAUD: prdata = {16'h0, baud_reg};
			`ASTF_OFS_CTRL1: prdata = {27'h0, ctrl1_reg};
			`ASTF_OFS_CTRL2: prdata = {28'h0, ctrl2_reg};
			`ASTF_OFS_CTRL3: prdata = {26'h0, ctrl3_reg, 4'h0};
			`ASTF_OFS_IRQ_EN: prdata = {25'h0, irq_en_reg};
			default: prdata = 32'h0;
		endcase
	end

	// Configuration registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_reg <= `ASTF_BAUD_RESET;
			ctrl1_reg <= 5'h00;
			ctrl3_reg <= 2'b00;
			irq_en_reg <= 7'h00;
		end else if (wr) begin
			if (paddr == `ASTF_OFS_BAUD)
				baud_reg <= pwdata[15:0];
			if (paddr == `ASTF_OFS_CTRL1)
				ctrl1_reg <= pwdata[4:0];
			if (paddr == `ASTF_OFS_CTRL3)
				ctrl3_reg <= pwdata[`ASTF_C3_STOP_HI:`ASTF_C3_STOP_LO];
			if (paddr == `ASTF_OFS_IRQ_EN)
				irq_en_reg <= pwdata[6:0];
		end
	end

	// Transmitter; break request bit lives in ctrl2 and is cleared by hardware
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl2_reg <= 4'h0;
			hold_reg <= 9'h000;
			hold_full_reg <= 1'b0;
			shift_reg <= 9'h000;
			state_reg <= S_IDLE;
			bit_cnt_reg <= 4'h0;
			tx_div_reg <= 16'h0000;
			tx_os_reg <= 4'h0;
			idle_pend_reg <= 1'b0;
			is_idle_reg <= 1'b0;
			ten_d_reg <= 1'b0;
			tx_out <= 1'b1;
			tx_oe <= 1'b0;
		end else begin
			ten_d_reg <= transmitter_enable;
			if (wr && paddr == `ASTF_OFS_CTRL2)
				ctrl2_reg <= pwdata[3:0];
			if (wr_data) begin
				hold_reg <= {ctrl1_reg[`ASTF_C1_NINTH], pwdata[7:0]};
				hold_full_reg <= 1'b1;
			end
			if (transmitter_enable && !ten_d_reg)
				idle_pend_reg <= 1'b1;
			tx_oe <= transmitter_enable;
			// Counters freeze while disabled, so a mid-frame disable corrupts that frame
			if (tx_tick) begin
				tx_div_reg <= div_max;
				tx_os_reg <= tx_os_reg + 4'h1;
			end else if (transmitter_enable)
				tx_div_reg <= tx_div_reg - 16'h0001;
			case (state_reg)
				S_IDLE: begin
					tx_out <= 1'b1;
					tx_os_reg <= 4'h0;
					if (transmitter_enable && (idle_pend_reg || (transmitter_enable && !ten_d_reg))) begin
						idle_pend_reg <= 1'b0;
						is_idle_reg <= 1'b1;
						state_reg <= S_START;
					end else if (transmitter_enable && ctrl2_reg[`ASTF_C2_BRK_REQ]) begin
						tx_out <= 1'b0;
						bit_cnt_reg <= 4'h0;
						state_reg <= S_BRK;
					end else if (transmitter_enable && hold_full_reg && !wr_data) begin
						shift_reg <= hold_word;
						hold_full_reg <= 1'b0;
						is_idle_reg <= 1'b0;
						tx_out <= 1'b0;
						state_reg <= S_START;
					end
				end
				S_START: begin
					tx_out <= is_idle_reg;
					if (tx_bit_end) begin
						bit_cnt_reg <= 4'h0;
						tx_out <= is_idle_reg | shift_reg[0];
						state_reg <= S_DATA;
					end
				end
				S_DATA: begin
					if (tx_bit_end) begin
						shift_reg <= {1'b0, shift_reg[8:1]};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						if (bit_cnt_reg == data_bits - 4'd1) begin
							bit_cnt_reg <= 4'h0;
							tx_out <= 1'b1;
							state_reg <= S_STOP;
						end else
							tx_out <= is_idle_reg | shift_reg[1];
					end
				end
				S_STOP: begin
					tx_out <= 1'b1;
					if (tx_bit_end) begin
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						if (frame_done)
							state_reg <= S_IDLE;
					end
				end
				S_BRK: begin
					tx_out <= 1'b0;
					if (tx_bit_end) begin
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						if (bit_cnt_reg == brk_bits - 4'd1) begin
							ctrl2_reg[`ASTF_C2_BRK_REQ] <= 1'b0;
							bit_cnt_reg <= 4'h0;
							tx_out <= 1'b1;
							state_reg <= S_STOP;
						end
					end
				end
				default: state_reg <= S_IDLE;
			endcase
			if (!transmitter_enable && state_reg == S_IDLE)
				idle_pend_reg <= 1'b0;
		end
	end

	// Receiver: majority of samples 7,8,9 of sixteen per bit
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_sync_reg <= 2'b11;
			rx_div_reg <= 16'h0000;
			rx_os_reg <= 4'h0;
			rx_samp_reg <= 3'b111;
			rx_busy_reg <= 1'b0;
			rx_bits_reg <= 4'h0;
			rx_shift_reg <= 9'h000;
			rx_data_reg <= 9'h000;
			rx_noise_reg <= 1'b0;
		end else begin
			rx_sync_reg <= {rx_sync_reg[0], rx_in};
			if (rx_tick)
				rx_div_reg <= div_max;
			else if (ren)
				rx_div_reg <= rx_div_reg - 16'h0001;
			if (!ren) begin
				rx_busy_reg <= 1'b0;
				rx_os_reg <= 4'h0;
			end else if (rx_tick) begin
				rx_os_reg <= rx_os_reg + 4'h1;
				if (rx_os_reg >= 4'd7 && rx_os_reg <= 4'd9)
					rx_samp_reg <= {rx_samp_reg[1:0], rx_sync_reg[1]};
				if (!rx_busy_reg) begin
					rx_os_reg <= 4'h0;
					if (!rx_sync_reg[1]) begin
						rx_busy_reg <= 1'b1;
						rx_bits_reg <= 4'h0;
						rx_noise_reg <= 1'b0;
						rx_os_reg <= 4'h1;
					end
				end else if (rx_os_reg == 4'hF) begin
					rx_bits_reg <= rx_bits_reg + 4'h1;
					if (rx_noisy)
						rx_noise_reg <= 1'b1;
					if (rx_bits_reg == 4'h0 && rx_bit)
						rx_busy_reg <= 1'b0;
					else if (rx_bits_reg == data_bits + 4'd1) begin
						rx_busy_reg <= 1'b0;
						if (!status_reg[`ASTF_ST_RXNE])
							rx_data_reg <= word9 ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
					end else if (rx_bits_reg != 4'h0)
						rx_shift_reg <= {rx_bit, rx_shift_reg[8:1]};
				end
			end
		end
	end

	wire rx_done = rx_tick && rx_busy_reg && (rx_os_reg == 4'hF)
		&& (rx_bits_reg == data_bits + 4'd1);
	wire rx_idle_frame = rx_done && (rx_shift_reg == 9'h1FF) && rx_bit;

	// Sticky status; a new event wins over a same-cycle clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status_reg <= 7'h01;
		else begin
			if (wr_clr)
				status_reg <= status_reg & ~pwdata[6:0];
			if (rd_data)
				status_reg[`ASTF_ST_RXNE] <= 1'b0;
			if (wr_data) begin
				status_reg[`ASTF_ST_TXE] <= 1'b0;
				status_reg[`ASTF_ST_TC] <= 1'b0;
			end
			if (!hold_full_reg && !wr_data)
				status_reg[`ASTF_ST_TXE] <= 1'b1;
			if (frame_done && !hold_full_reg && !wr_data)
				status_reg[`ASTF_ST_TC] <= 1'b1;
			if (rx_done) begin
				if (status_reg[`ASTF_ST_RXNE] && !rd_data)
					status_reg[`ASTF_ST_OVR] <= 1'b1;
				else
					status_reg[`ASTF_ST_RXNE] <= 1'b1;
				if (rx_noise_reg)
					status_reg[`ASTF_ST_NF] <= 1'b1;
				if (rx_noise_reg)
					status_reg[`ASTF_ST_PE] <= 1'b1;
			end
			if (rx_idle_frame)
				status_reg[`ASTF_ST_IDLE] <= 1'b1;
		end
	end
endmodule // astf_top
`default_nettype wire

// File: astf_map.vh
// Register map and constants for the asynchronous serial transmit framer
`ifndef ASTF_MAP_VH
`define ASTF_MAP_VH
`define ASTF_OFS_STATUS 12'h000
`define ASTF_OFS_DATA 12'h004
`define ASTF_OFS_BAUD 12'h008
`define ASTF_OFS_CTRL1 12'h00C
`define ASTF_OFS_CTRL2 12'h010
`define ASTF_OFS_CTRL3 12'h014
`define ASTF_OFS_IRQ_EN 12'h018
`define ASTF_OFS_IRQ_CLR 12'h01C
`define ASTF_C1_NINTH 0
`define ASTF_C1_WORD9 4
`define ASTF_C2_BRK_REQ 0
`define ASTF_C2_REN 2
`define ASTF_C2_TEN 3
`define ASTF_C3_STOP_LO 4
`define ASTF_C3_STOP_HI 5
`define ASTF_ST_TXE 0
`define ASTF_ST_TC 1
`define ASTF_ST_RXNE 2
`define ASTF_ST_IDLE 3
`define ASTF_ST_OVR 4
`define ASTF_ST_PE 5
`define ASTF_ST_NF 6
`define ASTF_IRQ_TX_MASK 7'h03
`define ASTF_IRQ_RX_MASK 7'h3C
`define ASTF_BAUD_RESET 16'h0010
`define ASTF_OVERSAMPLE 16
`endif

// File: astf_checker.sv
// Port assertions for the serial transmit framer
`timescale 1ns/1ps
`default_nettype none
module astf_checker #(parameter int BIT = 16) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// Serial line
	input wire logic tx_out,
	input wire logic tx_oe,
	// Interrupts
	input wire logic irq,
	input wire logic irq_tx,
	input wire logic irq_rx
);
	logic [10:0] low_run;
	logic [10:0] high_run;
	logic [10:0] en_cnt;
	// Run lengths saturate so a long idle never wraps into a false short run
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_run <= 11'h000;
			high_run <= 11'h000;
			en_cnt <= 11'h000;
		end else begin
			low_run <= tx_out ? 11'h000 : (&low_run ? low_run : low_run + 11'h001);
			high_run <= !tx_out ? 11'h000 : (&high_run ? high_run : high_run + 11'h001);
			en_cnt <= !tx_oe ? 11'h000 : (&en_cnt ? en_cnt : en_cnt + 11'h001);
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_start_min: assert property ($rose(tx_out) && tx_oe |-> low_run >= BIT)
		else $error("low period shorter than one bit");
	a_bit_grid: assert property ($rose(tx_out) && tx_oe |-> low_run % BIT == 0)
		else $error("low period off the bit grid");
	a_break_max: assert property ($rose(tx_out) && tx_oe |-> low_run <= 11 * BIT)
		else $error("low period longer than eleven bits");
	a_stop_min: assert property ($fell(tx_out) && tx_oe |-> high_run >= BIT)
		else $error("high period shorter than one stop bit");
	a_idle_first: assert property ($fell(tx_out) && tx_oe |-> en_cnt >= 10 * BIT - 1)
		else $error("start bit before the idle frame ended");
	// Enable lands at the write edge, the registered pin drive one edge later
	a_oe_follow: assert property (psel && penable && pwrite && paddr == 12'h010
		|-> ##2 tx_oe == $past(pwdata[3], 2))
		else $error("pin drive does not follow enable");
	a_frozen_line: assert property (!tx_oe && !$past(tx_oe) |-> $stable(tx_out))
		else $error("line moved while transmitter disabled");
	a_irq_mask: assert property (psel && penable && pwrite && paddr == 12'h018
		&& pwdata[6:0] == 7'h00 |=> !irq && !irq_tx && !irq_rx)
		else $error("interrupt raised with all sources masked");
	c_enable: cover property ($rose(tx_oe));
	c_break: cover property ($rose(tx_out) && low_run >= 10 * BIT);
	c_irq: cover property ($rose(irq));
endmodule // astf_checker
bind astf_top astf_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .tx_out, .tx_oe, .irq, .irq_tx, .irq_rx);
`default_nettype wire

// File: astf_line_model.sv
// Remote serial transceiver: decodes frames and can echo the line back
`timescale 1ns/1ps
`default_nettype none
module astf_line_model (
	// Clock
	input wire logic pclk,
	// Line from framer
	input wire logic tx_out,
	input wire logic tx_oe,
	// Setup
	input wire logic word9,
	input wire logic loop,
	// Results
	output logic rx_in,
	output logic [8:0] got,
	output logic got_brk,
	output int got_cnt
);
	logic [8:0] w;
	logic line;
	// Released pin is pulled up; no loop keeps our own line idle high
	assign line = tx_oe ? tx_out : 1'b1;
	assign rx_in = loop ? line : 1'b1;
	initial begin
		got = 9'h000;
		got_brk = 1'b0;
		got_cnt = 0;
		forever begin
			@(negedge line);
			repeat (8) @(posedge pclk);
			if (line === 1'b0) begin
				w = 9'h000;
				for (int i = 0; i < (word9 ? 9 : 8); i++) begin
					repeat (16) @(posedge pclk);
					w[i] = line;
				end
				repeat (16) @(posedge pclk);
				got = w;
				got_brk = !line;
				got_cnt++;
				if (!line) @(posedge line);
			end
		end
	end
endmodule // astf_line_model
`default_nettype wire

// File: astf_top_tb.sv
// Self-checking bench for the serial transmit framer
`timescale 1ns/1ps
`default_nettype none
module astf_top_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, w9 = 0, loop = 0, se;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	wire [31:0] prdata;
	wire pready, pslverr, tx_out, tx_oe, irq, irq_tx, irq_rx, rx_in, got_brk;
	wire [8:0] got;
	int got_cnt, errors = 0, n_compared = 0, cyc = 0;
	astf_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_out(tx_out), .tx_oe(tx_oe), .rx_in(rx_in), .irq(irq),
		.irq_tx(irq_tx), .irq_rx(irq_rx));
	astf_line_model far_u (.pclk(pclk), .tx_out(tx_out), .tx_oe(tx_oe), .word9(w9),
		.loop(loop), .rx_in(rx_in), .got(got), .got_brk(got_brk), .got_cnt(got_cnt));
	initial forever #50 pclk = ~pclk;
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			finish_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
		n_compared++;
		if (a !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, a);
		end
	endtask
	// Read data is taken at the edge where pready is seen high; one more edge lets outputs settle
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_rx(input int n);
		for (int k = 0; k < 3000 && got_cnt < n; k++) @(posedge pclk);
		chk("frames", n, got_cnt);
	endtask
	task automatic t_reset();
		bus(0, 12'h000, 0);
		chk("status", 32'h1, rd);
		bus(0, 12'h008, 0);
		chk("baud", 32'h10, rd);
		bus(0, 12'h014, 0);
		chk("stops", 32'h0, rd);
		bus(0, 12'h040, 0);
		chk("slverr", 1, se);
		chk("unmapped", 0, rd);
		$display("test reset done");
	endtask
	task automatic t_byte();
		bus(1, 12'h008, 32'h1);
		bus(1, 12'h010, 32'h8);
		bus(1, 12'h004, 32'hA5);
		wait_rx(1);
		chk("byte", 9'h0A5, got);
		$display("test byte done");
	endtask
	task automatic t_irq();
		repeat (40) @(posedge pclk);
		bus(1, 12'h018, 32'h0);
		chk("masked", 0, irq);
		bus(1, 12'h018, 32'h2);
		chk("irq", 1, irq);
		chk("irq_tx", 1, irq_tx);
		bus(1, 12'h01C, 32'h2);
		chk("cleared", 0, irq);
		$display("test irq done");
	endtask
	task automatic t_nine();
		w9 <= 1'b1;
		bus(1, 12'h00C, 32'h11);
		bus(1, 12'h004, 32'h3C);
		wait_rx(2);
		chk("ninth", 9'h13C, got);
		bus(1, 12'h00C, 32'h0);
		w9 <= 1'b0;
		$display("test nine done");
	endtask
	task automatic t_pair();
		bus(1, 12'h014, 32'h10);
		bus(1, 12'h004, 32'h11);
		bus(1, 12'h004, 32'h22);
		wait_rx(3);
		chk("first", 9'h011, got);
		wait_rx(4);
		chk("second", 9'h022, got);
		bus(1, 12'h014, 32'h0);
		$display("test pair done");
	endtask
	task automatic t_break();
		bus(1, 12'h010, 32'h9);
		wait_rx(5);
		chk("break", 1, got_brk);
		repeat (400) @(posedge pclk);
		bus(0, 12'h010, 0);
		chk("brk_req", 32'h8, rd);
		$display("test break done");
	endtask
	task automatic t_rx();
		loop <= 1'b1;
		bus(1, 12'h010, 32'hC);
		bus(1, 12'h004, 32'h5A);
		wait_rx(6);
		repeat (40) @(posedge pclk);
		bus(0, 12'h000, 0);
		chk("rxne", 1, rd[2]);
		bus(1, 12'h018, 32'h4);
		chk("irq_rx", 1, irq_rx);
		bus(0, 12'h004, 0);
		chk("rxdata", 8'h5A, rd[7:0]);
		chk("irq_rx_off", 0, irq_rx);
		$display("test rx done");
	endtask
	task automatic t_off();
		bus(1, 12'h010, 32'h0);
		@(posedge pclk);
		chk("oe", 0, tx_oe);
		$display("test off done");
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_byte();
		t_irq();
		t_nine();
		t_pair();
		t_break();
		t_rx();
		t_off();
		finish_test();
	end
endmodule // astf_top_tb
`default_nettype wire
